// ---- hw/msc_pkg.sv ----
// Shared constants, state enums and state records for both ends of the
// module sideband link (select, reset, low power, presence, interrupt, 2-wire).
// Assumes a single 10 MHz system clock at each end.
package msc_pkg;

  // Clock rate and timing figures
  localparam int CLK_MHZ = 10;
  localparam int RESET_MIN_US = 10;
  localparam logic [15:0] RESET_MIN_CYC = 16'(RESET_MIN_US * CLK_MHZ);
  localparam logic [15:0] HOST_RESET_CYC = 16'(2 * RESET_MIN_US * CLK_MHZ);
  localparam int INIT_US = 2000;
  localparam int SCL_QTR_NS = 500;
  localparam logic [3:0] SCL_QTR_CYC = 4'(SCL_QTR_NS * CLK_MHZ / 1000);
  localparam int CNT_W = 24;

  // Bus address and management byte offsets
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam logic [7:0] OFS_IDENT = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h01;
  localparam logic [7:0] OFS_FLAGS = 8'h02;
  localparam logic [7:0] OFS_MASK = 8'h03;

  // Field positions and reset values
  localparam int STS_INIT_BIT = 0;
  localparam int STS_LP_BIT = 1;
  localparam int FLG_INIT_BIT = 0;
  localparam int FAULT_W = 4;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // Synchroniser lanes, device side then host side
  localparam int P_SEL = 0;
  localparam int P_RST = 1;
  localparam int P_LP = 2;
  localparam int P_SCL = 3;
  localparam int P_SDA = 4;
  localparam logic [4:0] DEV_PINS_IDLE = 5'h1b;
  localparam int H_INT = 0;
  localparam int H_PRS = 1;
  localparam int H_SDA = 2;
  localparam logic [2:0] HOST_PINS_IDLE = 3'h7;

  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_OFFS, D_WDAT, D_RDAT} msc_dev_state_type;
  typedef enum logic [3:0] {H_IDLE, H_START, H_ADDR, H_OFFS, H_WDAT, H_RSTART, H_RADDR,
    H_READ, H_STOP} msc_host_state_type;

  typedef struct packed {
    logic [4:0] sy0;
    logic [4:0] sy1;
    logic [4:0] sy2;
    logic [4:0] flt;
    msc_dev_state_type st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic sda_low;
    logic [15:0] rcnt;
    logic rst_hit;
    logic [CNT_W-1:0] icnt;
    logic init_pending;
    logic [7:0] flags;
    logic [7:0] mask;
    logic lp;
    logic irq;
  } msc_dev_type;

  typedef struct packed {
    logic [2:0] sy0;
    logic [2:0] sy1;
    logic [2:0] sy2;
    logic [2:0] flt;
    msc_host_state_type st;
    logic [1:0] q;
    logic [3:0] qcnt;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic scl;
    logic sda;
    logic write;
    logic auto;
    logic armed;
    logic [7:0] offs;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic nack;
    logic rsp_valid;
    logic flags_valid;
    logic [15:0] rst_cnt;
    logic rst_low;
    logic waiting;
    logic lp;
  } msc_host_type;

endpackage

// ---- hw/msc_link_if.sv ----
// Sideband link between host controller and pluggable module.
// Assumes both ends give open-drain pins as output plus active-low enable;
// pull-ups are resolved here.
`timescale 1ns/1ps
`default_nettype none
interface msc_link_if;
  logic scl;
  logic h_sda_o;
  logic h_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  logic sda;
  logic sel_o;
  logic sel_oe_n;
  logic select_n;
  logic module_reset_n;
  logic low_power_select;
  logic prs_o;
  logic prs_oe_n;
  logic presence_n;
  logic int_o;
  logic int_oe_n;
  logic interrupt_n;

  // Wired-AND with pull-up on the shared data line
  assign sda = ~((~h_sda_oe_n & ~h_sda_o) | (~d_sda_oe_n & ~d_sda_o));
  // Module pull-up: an undriven select reads deselected
  assign select_n = sel_oe_n ? 1'h1 : sel_o;
  // Host pull-up on presence and interrupt
  assign presence_n = prs_oe_n ? 1'h1 : prs_o;
  assign interrupt_n = int_oe_n ? 1'h1 : int_o;

  modport dev (
    input scl, sda, select_n, module_reset_n, low_power_select,
    output d_sda_o, d_sda_oe_n, prs_o, prs_oe_n, int_o, int_oe_n
  );
  modport host (
    input sda, presence_n, interrupt_n,
    output scl, h_sda_o, h_sda_oe_n, sel_o, sel_oe_n, module_reset_n, low_power_select
  );
endinterface
`default_nettype wire

// ---- hw/msc_device.sv ----
// Module end of the sideband link: select gating, reset timing, init
// completion interrupt, low power, presence and a small 2-wire slave.
// Assumes the host drives select, reset, low power and the 2-wire clock,
// and that pull-ups are resolved in the link interface.
//
// How it works
// - Selected module answers 2-wire commands
// - Deselected module ignores bus, never drives
// - Select has pull-up, undriven means deselected
// - Long reset low restores all defaults
// - Init interval starts at reset release
// - Host ignores status until completion interrupt
// - Init done raises interrupt, pending bit cleared
// - Power-up also posts completion interrupt
// - Low power input high reduces power
// - Presence grounded here, pulled up by host
// - Interrupt low flags fault or critical status
// - Host reads bus to find interrupt source
// - Interrupt is open-drain, host pulls up
// - Host reads flag byte after interrupt
// - Module answers at fixed bus address
`timescale 1ns/1ps
`default_nettype none
module msc_device
  import msc_pkg::*;
#(
  parameter int INIT_CYC = INIT_US * CLK_MHZ,
  parameter logic [7:0] IDENT = 8'h00 // Identifier byte, value arbitrary
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link pins
  msc_link_if.dev link,
  // Fault events from the module core, one-cycle pulses
  input wire logic [FAULT_W-1:0] fault_event,
  // Module core controls and status
  output logic low_power,
  output logic module_ready,
  output logic full_reset
);

  msc_dev_type r;
  msc_dev_type next_r;
  logic [4:0] pin_in;

  // Raw pins in synchroniser lane order
  assign pin_in = {link.sda, link.scl, link.low_power_select, link.module_reset_n,
    link.select_n};

  // Next-state logic for the whole module end
  always_comb
  begin
    logic [4:0] rise;
    logic [4:0] fall;
    logic start;
    logic stop;
    logic fire;
    logic [7:0] rd;
    logic [7:0] clr;
    rise = 5'h00;
    fall = 5'h00;
    start = 1'h0;
    stop = 1'h0;
    fire = 1'h0;
    rd = 8'h00;
    clr = 8'h00;
    next_r = r;

    // Three flops; a level counts once the last two agree
    next_r.sy0 = pin_in;
    next_r.sy1 = r.sy0;
    next_r.sy2 = r.sy1;
    next_r.flt = (r.sy1 & r.sy2) | (r.flt & (r.sy1 ^ r.sy2));
    rise = next_r.flt & ~r.flt;
    fall = ~next_r.flt & r.flt;
    start = fall[P_SDA] & r.flt[P_SCL] & next_r.flt[P_SCL];
    stop = rise[P_SDA] & r.flt[P_SCL] & next_r.flt[P_SCL];

    // Low power follows the filtered pin
    next_r.lp = next_r.flt[P_LP];

    // Measure reset low time; short glitches below the minimum do nothing
    if (!next_r.flt[P_RST])
    begin
      if (r.rcnt == RESET_MIN_CYC)
        next_r.rst_hit = 1'h1;
      else
        next_r.rcnt = r.rcnt + 16'h0001;
    end
    else
    begin
      next_r.rcnt = 16'h0000;
      next_r.rst_hit = 1'h0;
    end

    // Full reset held while the line stays low; settings back to default
    if (next_r.rst_hit)
    begin
      next_r.mask = MASK_RESET;
      next_r.init_pending = 1'h1;
      next_r.icnt = '0;
    end
    else if (r.init_pending && next_r.flt[P_RST])
    begin
      // Same timer serves power-up and host reset
      if (r.icnt == CNT_W'(INIT_CYC - 1))
      begin
        next_r.init_pending = 1'h0;
        fire = 1'h1;
      end
      else
        next_r.icnt = r.icnt + 1'h1;
    end

    // Read data for the byte at the pointer
    case (r.ptr)
      OFS_IDENT: rd = IDENT;
      OFS_STATUS: rd = {6'h00, r.lp, r.init_pending};
      OFS_FLAGS: rd = r.flags;
      OFS_MASK: rd = r.mask;
      default: rd = 8'h00;
    endcase

    // 2-wire slave; deselect or reset drops everything and frees the line
    if (next_r.flt[P_SEL] || next_r.rst_hit)
    begin
      next_r.st = D_IDLE;
      next_r.sda_low = 1'h0;
    end
    else if (start)
    begin
      next_r.st = D_ADDR;
      next_r.cnt = 4'h0;
      next_r.sda_low = 1'h0;
    end
    else if (stop)
    begin
      next_r.st = D_IDLE;
      next_r.sda_low = 1'h0;
    end
    else if (r.st != D_IDLE)
    begin
      if (rise[P_SCL])
      begin
        if (r.st == D_RDAT)
        begin
          // Ninth clock carries the host acknowledge; a nack ends the read
          if (r.cnt == 4'h8)
          begin
            if (next_r.flt[P_SDA])
              next_r.st = D_IDLE;
            else
              next_r.cnt = 4'h9;
          end
          else
            next_r.cnt = r.cnt + 4'h1;
        end
        else if (r.cnt < 4'h8)
        begin
          next_r.sh = {r.sh[6:0], next_r.flt[P_SDA]};
          next_r.cnt = r.cnt + 4'h1;
        end
      end
      if (fall[P_SCL])
      begin
        if (r.cnt == 4'h9)
        begin
          // End of an acknowledge bit: release and move on
          next_r.cnt = 4'h0;
          next_r.sda_low = 1'h0;
          if (r.st == D_ADDR)
            next_r.st = r.rw ? D_RDAT : D_OFFS;
          else if (r.st == D_OFFS)
            next_r.st = D_WDAT;
          if (r.st == D_RDAT || (r.st == D_ADDR && r.rw))
          begin
            // Load a byte; reading the flag byte clears what was read
            next_r.sh = rd;
            next_r.sda_low = ~rd[7];
            next_r.ptr = r.ptr + 8'h01;
            if (r.ptr == OFS_FLAGS)
              clr = r.flags;
          end
        end
        else if (r.cnt == 4'h8 && r.st != D_RDAT)
        begin
          next_r.cnt = 4'h9;
          next_r.sda_low = 1'h1;
          case (r.st)
            D_ADDR:
            begin
              // Only our own address is acknowledged
              if (r.sh[7:1] == DEV_ADDR)
                next_r.rw = r.sh[0];
              else
              begin
                next_r.st = D_IDLE;
                next_r.sda_low = 1'h0;
              end
            end
            D_OFFS: next_r.ptr = r.sh;
            default:
            begin
              // Writes during init are acked but dropped
              if (r.ptr == OFS_MASK && !r.init_pending)
                next_r.mask = r.sh;
              next_r.ptr = r.ptr + 8'h01;
            end
          endcase
        end
        else if (r.st == D_RDAT)
        begin
          // Shift out the next bit, free the line for the host ack
          if (r.cnt == 4'h8)
            next_r.sda_low = 1'h0;
          else
          begin
            next_r.sh = {r.sh[6:0], 1'h0};
            next_r.sda_low = ~r.sh[6];
          end
        end
      end
    end

    // Sticky flags: a new event beats a clear in the same cycle
    if (next_r.rst_hit)
      next_r.flags = 8'h00;
    else
      next_r.flags = (r.flags & ~clr) | {3'h0, fault_event, fire};

    // Interrupt while any unmasked flag stands, never during init
    next_r.irq = (|(next_r.flags & ~next_r.mask)) & ~next_r.init_pending;
  end

  // State register; sync chains start at idle pin levels
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      r <= '0;
      r.sy0 <= DEV_PINS_IDLE;
      r.sy1 <= DEV_PINS_IDLE;
      r.sy2 <= DEV_PINS_IDLE;
      r.flt <= DEV_PINS_IDLE;
      r.st <= D_IDLE;
      r.mask <= MASK_RESET;
      r.init_pending <= 1'h1;
    end
    else
      r <= next_r;
  end

  // Open-drain pins: only ever pull low or let go
  assign link.d_sda_o = 1'h0;
  assign link.d_sda_oe_n = ~r.sda_low;
  assign link.int_o = 1'h0;
  assign link.int_oe_n = ~r.irq;
  // Presence tied to ground inside the module
  assign link.prs_o = 1'h0;
  assign link.prs_oe_n = 1'h0;

  // Core-facing outputs
  assign low_power = r.lp;
  assign module_ready = ~r.init_pending;
  assign full_reset = r.rst_hit;

endmodule // msc_device
`default_nettype wire

// ---- hw/msc_host.sv ----
// Host end of the sideband link: drives select, reset and low power,
// generates the 2-wire clock by division and reads flags on interrupt.
// Assumes the module end answers as a 2-wire slave at the fixed address.
`timescale 1ns/1ps
`default_nettype none
module msc_host
  import msc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link pins
  msc_link_if.host link,
  // Command request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_offset,
  input wire logic [7:0] cmd_wdata,
  // Command answer
  output logic rsp_valid,
  output logic rsp_nack,
  output logic [7:0] rsp_rdata,
  // Sideband controls
  input wire logic reset_req,
  input wire logic low_power_req,
  // Status
  output logic module_present,
  output logic irq_seen,
  output logic status_valid,
  output logic flags_valid
);

  msc_host_type r;
  msc_host_type next_r;
  logic auto_need;

  // Interrupt read takes priority over user commands
  assign auto_need = r.armed & ~r.flt[H_INT];
  assign cmd_ready = (r.st == H_IDLE) & ~r.rst_low & ~reset_req & ~auto_need;

  // Next-state logic
  always_comb
  begin
    logic qend;
    logic tx;
    qend = (r.qcnt == SCL_QTR_CYC - 4'h1);
    tx = (r.st == H_ADDR) | (r.st == H_OFFS) | (r.st == H_WDAT) | (r.st == H_RADDR);
    next_r = r;
    next_r.rsp_valid = 1'h0;
    next_r.flags_valid = 1'h0;
    next_r.sy0 = {link.sda, link.presence_n, link.interrupt_n};
    next_r.sy1 = r.sy0;
    next_r.sy2 = r.sy1;
    next_r.flt = (r.sy1 & r.sy2) | (r.flt & (r.sy1 ^ r.sy2));
    next_r.lp = low_power_req;
    if (r.flt[H_INT])
      next_r.armed = 1'h1;

    // Reset pulse held past the module's minimum, then wait for completion
    if (r.rst_low)
    begin
      if (r.rst_cnt == HOST_RESET_CYC - 16'h0001)
        next_r.rst_low = 1'h0;
      else
        next_r.rst_cnt = r.rst_cnt + 16'h0001;
    end
    else if (reset_req && r.st == H_IDLE)
    begin
      next_r.rst_low = 1'h1;
      next_r.rst_cnt = 16'h0000;
      next_r.waiting = 1'h1;
    end

    if (r.st == H_IDLE)
    begin
      if (auto_need && !r.rst_low && !reset_req)
      begin
        next_r.auto = 1'h1;
        next_r.write = 1'h0;
        next_r.offs = OFS_FLAGS;
        next_r.armed = 1'h0;
        next_r.st = H_START;
      end
      else if (cmd_valid && cmd_ready)
      begin
        next_r.auto = 1'h0;
        next_r.write = cmd_write;
        next_r.offs = cmd_offset;
        next_r.wdata = cmd_wdata;
        next_r.st = H_START;
      end
      next_r.q = 2'h0;
      next_r.qcnt = 4'h0;
      next_r.nack = 1'h0;
    end
    else
    begin
      next_r.qcnt = qend ? 4'h0 : r.qcnt + 4'h1;
      if (qend)
      begin
        next_r.q = r.q + 2'h1;
        // Sample late in the high phase, after the sync delay
        if (r.q == 2'h2 && tx && r.bitn == 4'h8)
          next_r.nack = r.flt[H_SDA];
        if (r.q == 2'h2 && r.st == H_READ && r.bitn != 4'h8)
          next_r.rdata = {r.rdata[6:0], r.flt[H_SDA]};
        if (r.q == 2'h3)
        begin
          case (r.st)
            H_START:
            begin
              next_r.st = H_ADDR;
              next_r.sh = {DEV_ADDR, 1'h0};
              next_r.bitn = 4'h0;
            end
            H_RSTART:
            begin
              next_r.st = H_RADDR;
              next_r.sh = {DEV_ADDR, 1'h1};
              next_r.bitn = 4'h0;
            end
            H_READ:
            begin
              if (r.bitn != 4'h8)
                next_r.bitn = r.bitn + 4'h1;
              else
                next_r.st = H_STOP;
            end
            H_STOP:
            begin
              next_r.st = H_IDLE;
              if (r.auto)
              begin
                next_r.flags_valid = ~r.nack;
                if (!r.nack && r.rdata[FLG_INIT_BIT])
                  next_r.waiting = 1'h0;
              end
              else
                next_r.rsp_valid = 1'h1;
            end
            default:
            begin
              if (r.bitn != 4'h8)
              begin
                next_r.bitn = r.bitn + 4'h1;
                next_r.sh = {r.sh[6:0], 1'h0};
              end
              else
              begin
                next_r.bitn = 4'h0;
                if (r.nack)
                  next_r.st = H_STOP;
                else if (r.st == H_ADDR)
                begin
                  next_r.st = H_OFFS;
                  next_r.sh = r.offs;
                end
                else if (r.st == H_OFFS)
                begin
                  next_r.st = r.write ? H_WDAT : H_RSTART;
                  next_r.sh = r.wdata;
                end
                else if (r.st == H_WDAT)
                  next_r.st = H_STOP;
                else
                  next_r.st = H_READ;
              end
            end
          endcase
        end
      end
    end

    // Pin pattern per quarter bit; data bits move only while the clock is low, start, repeated start and stop while it is high
    case (r.st)
      H_IDLE:
      begin
        next_r.scl = 1'h1;
        next_r.sda = 1'h1;
      end
      H_START:
      begin
        next_r.scl = (r.q != 2'h3);
        next_r.sda = (r.q == 2'h0);
      end
      H_RSTART:
      begin
        next_r.scl = r.q[0] ^ r.q[1];
        next_r.sda = ~r.q[1];
      end
      H_STOP:
      begin
        next_r.scl = (r.q != 2'h0);
        next_r.sda = r.q[1];
      end
      H_READ:
      begin
        next_r.scl = r.q[0] ^ r.q[1];
        next_r.sda = 1'h1;
      end
      default:
      begin
        next_r.scl = r.q[0] ^ r.q[1];
        next_r.sda = (r.bitn == 4'h8) | r.sh[7];
      end
    endcase
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      r <= '0;
      r.sy0 <= HOST_PINS_IDLE;
      r.sy1 <= HOST_PINS_IDLE;
      r.sy2 <= HOST_PINS_IDLE;
      r.flt <= HOST_PINS_IDLE;
      r.st <= H_IDLE;
      r.scl <= 1'h1;
      r.sda <= 1'h1;
      r.armed <= 1'h1;
      r.waiting <= 1'h1;
    end
    else
      r <= next_r;
  end

  // Link pins; select is released, hence pulled high, between transfers
  assign link.scl = r.scl;
  assign link.h_sda_o = 1'h0;
  assign link.h_sda_oe_n = r.sda;
  assign link.sel_o = 1'h0;
  assign link.sel_oe_n = (r.st == H_IDLE);
  assign link.module_reset_n = ~r.rst_low;
  assign link.low_power_select = r.lp;

  // User-side answers
  assign rsp_valid = r.rsp_valid;
  assign rsp_nack = r.nack;
  assign rsp_rdata = r.rdata;
  assign flags_valid = r.flags_valid;
  assign module_present = ~r.flt[H_PRS];
  assign irq_seen = ~r.flt[H_INT];
  assign status_valid = ~r.waiting;

endmodule // msc_host
`default_nettype wire

// ---- tb/msc_monitor.sv ----
// Checker on the sideband link pins, seeing both ends at once.
// Assumes the bench places it beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module msc_monitor
  import msc_pkg::*;
#(
  parameter int INIT_CYC = 50
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link pins
  input wire logic scl,
  input wire logic d_sda_o,
  input wire logic d_sda_oe_n,
  input wire logic select_n,
  input wire logic module_reset_n,
  input wire logic presence_n,
  input wire logic int_o,
  input wire logic int_oe_n
);
  int hi_cnt;
  int lo_cnt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Cycles since the reset line went high, and cycles it has been held low
  always_ff @(posedge clk)
  begin
    if (!rst_b || !module_reset_n) hi_cnt <= 0;
    else if (hi_cnt < 100000) hi_cnt <= hi_cnt + 1;
    if (!rst_b || module_reset_n) lo_cnt <= 0;
    else if (lo_cnt < 100000) lo_cnt <= lo_cnt + 1;
  end

  // Six cycles of margin cover the receiver's synchroniser
  desel_quiet_a: assert property (select_n [*6] |-> d_sda_oe_n)
    else $error("module drives data while deselected");
  presence_low_a: assert property (presence_n == 1'b0)
    else $error("presence not low");
  open_drain_a: assert property ((int_oe_n || !int_o) && (d_sda_oe_n || !d_sda_o))
    else $error("open-drain pin driven high");
  reset_clear_a: assert property (lo_cnt > int'(RESET_MIN_CYC) + 10 |-> int_oe_n)
    else $error("interrupt survives full reset");
  init_quiet_a: assert property (module_reset_n && hi_cnt < INIT_CYC |-> int_oe_n)
    else $error("interrupt before init interval ends");
  init_done_a: assert property (hi_cnt == INIT_CYC + 12 |-> !int_oe_n)
    else $error("no completion interrupt after init");
  int_held_a: assert property ($rose(int_oe_n) |-> !select_n || lo_cnt > 0)
    else $error("interrupt released without a bus access");
  sda_in_low_a: assert property ($changed(d_sda_oe_n) |-> !scl)
    else $error("module data changed while clock high");
  scl_sel_a: assert property ($fell(scl) |-> !select_n)
    else $error("bus clocked without select");
endmodule // msc_monitor
`default_nettype wire

// ---- tb/tb.sv ----
// Bench joining host and module ends through the link interface.
// Assumes a 10 MHz clock; the init interval is shortened by parameter.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import msc_pkg::*;
  localparam int INIT_SIM = 50;
  localparam logic [7:0] IDENT_SIM = 8'h5a; // Arbitrary identifier
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [FAULT_W-1:0] fault_event = '0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [7:0] cmd_offset = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic reset_req = 1'b0;
  logic low_power_req = 1'b0;
  logic cmd_ready, rsp_valid, rsp_nack, low_power, module_ready, full_reset;
  logic module_present, irq_seen, status_valid, flags_valid;
  logic [7:0] rsp_rdata;
  logic [7:0] rd;
  int num_errors = 0;
  int samples_checked = 0;
  int mask_m, lp_m, v;
  // Model of the sticky fault flags, bits 4:1
  int flags_m = 0;

  msc_link_if link ();
  msc_device #(.INIT_CYC(INIT_SIM), .IDENT(IDENT_SIM)) msc_device_inst (.clk(clk),
    .rst_b(rst_b), .link(link.dev), .fault_event(fault_event), .low_power(low_power),
    .module_ready(module_ready), .full_reset(full_reset));
  msc_host msc_host_inst (.clk(clk), .rst_b(rst_b), .link(link.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_offset(cmd_offset), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata), .reset_req(reset_req),
    .low_power_req(low_power_req), .module_present(module_present), .irq_seen(irq_seen),
    .status_valid(status_valid), .flags_valid(flags_valid));
  msc_monitor #(.INIT_CYC(INIT_SIM)) msc_monitor_inst (.clk(clk), .rst_b(rst_b),
    .scl(link.scl), .d_sda_o(link.d_sda_o), .d_sda_oe_n(link.d_sda_oe_n),
    .select_n(link.select_n), .module_reset_n(link.module_reset_n),
    .presence_n(link.presence_n), .int_o(link.int_o), .int_oe_n(link.int_oe_n));

  // Clock
  always #50 clk = ~clk;

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask

  // One command: held until taken, answer picked up at the pulse edge
  task automatic cmd(input logic wr, input logic [7:0] ofs, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_offset <= ofs;
    cmd_wdata <= wd;
    @(posedge clk);
    while (cmd_ready !== 1'b1 && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    cmd_valid <= 1'b0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rsp_valid !== 1'b1 && n < 5000);
    chk_bit(rsp_valid, 1'b1);
    chk_bit(rsp_nack, 1'b0);
    rd = rsp_rdata;
  endtask

  // Waits for the host's own read after an interrupt
  task automatic wait_flags(input logic [7:0] exp);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (flags_valid !== 1'b1 && n < 5000);
    chk_bit(flags_valid, 1'b1);
    chk_byte(rsp_rdata, exp);
    // The flag read clears what it returned
    flags_m = 0;
  endtask

  task automatic pulse(input logic [FAULT_W-1:0] f);
    @(posedge clk);
    fault_event <= f;
    flags_m = flags_m | (int'(f) << 1);
    @(posedge clk);
    fault_event <= '0;
  endtask

  task automatic end_test(input string name);
    $display("Test %s done at %0t", name, $time);
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run of some 15000 cycles
  initial
  begin
    repeat (90000) @(posedge clk);
    num_errors++;
    final_report();
  end

  initial
  begin
    void'($urandom(32'hf158));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // Power-up posts the completion interrupt by itself
    chk_bit(status_valid, 1'b0);
    chk_bit(module_ready, 1'b0);
    wait_flags(8'h01);
    repeat (10) @(posedge clk);
    chk_bit(status_valid, 1'b1);
    chk_bit(module_ready, 1'b1);
    chk_bit(link.interrupt_n, 1'b1);
    chk_bit(module_present, 1'b1);
    end_test("power-up");
    // Byte map: identifier is read-only, unused offsets read zero
    cmd(1'b1, OFS_IDENT, 8'hff);
    cmd(1'b0, OFS_IDENT, 8'h00);
    chk_byte(rd, IDENT_SIM);
    v = $urandom_range(255, 4);
    cmd(1'b0, v[7:0], 8'h00);
    chk_byte(rd, 8'h00);
    mask_m = $urandom_range(255, 0);
    cmd(1'b1, OFS_MASK, mask_m[7:0]);
    cmd(1'b0, OFS_MASK, 8'h00);
    chk_byte(rd, mask_m[7:0]);
    end_test("byte map");
    // Low power set then cleared
    for (int i = 0; i < 2; i++)
    begin
      lp_m = 1 - i;
      low_power_req <= lp_m[0];
      repeat (20) @(posedge clk);
      chk_bit(low_power, lp_m[0]);
      cmd(1'b0, OFS_STATUS, 8'h00);
      chk_byte(rd, {6'h00, lp_m[0], 1'b0});
    end
    end_test("low power");
    // Every fault source raises the interrupt; the read releases it
    cmd(1'b1, OFS_MASK, 8'h00);
    for (int i = 0; i < FAULT_W; i++)
    begin
      pulse(FAULT_W'(1 << i));
      // Host must see the line low before its own read releases it
      repeat (10) @(posedge clk);
      chk_bit(irq_seen, 1'b1);
      wait_flags(8'(2 << i));
      repeat (10) @(posedge clk);
      chk_bit(link.interrupt_n, 1'b1);
      chk_bit(irq_seen, 1'b0);
    end
    // Masked faults set flags quietly; flags clear on read
    v = $urandom_range(15, 1);
    cmd(1'b1, OFS_MASK, 8'(v << 1));
    pulse(v[FAULT_W-1:0]);
    repeat (100) @(posedge clk);
    chk_bit(link.interrupt_n, 1'b1);
    chk_bit(irq_seen, 1'b0);
    cmd(1'b0, OFS_FLAGS, 8'h00);
    chk_byte(rd, 8'(flags_m));
    flags_m = 0;
    cmd(1'b0, OFS_FLAGS, 8'h00);
    chk_byte(rd, 8'(flags_m));
    end_test("faults");
    // Host reset pulse restores defaults and repeats the init interrupt;
    // an unmasked fault is left standing so the reset has something to clear
    cmd(1'b1, OFS_MASK, 8'h80);
    pulse(v[FAULT_W-1:0]);
    reset_req <= 1'b1;
    for (int n = 0; n < 50 && link.module_reset_n !== 1'b0; n++) @(posedge clk);
    reset_req <= 1'b0;
    repeat (150) @(posedge clk);
    chk_bit(full_reset, 1'b1);
    chk_bit(status_valid, 1'b0);
    wait_flags(8'h01);
    cmd(1'b0, OFS_MASK, 8'h00);
    chk_byte(rd, MASK_RESET);
    chk_bit(full_reset, 1'b0);
    end_test("host reset");
    final_report();
  end
endmodule // tb
`default_nettype wire
